// ### verilog/sdc_pkg.sv
package sdc_pkg;
	// ============================================================
	// register map (byte offsets on the plain register port)
	localparam logic [7:0] ADDR_MODE_ONE = 8'h93;
	localparam logic [7:0] ADDR_MODE_TWO = 8'h94;
	localparam logic [7:0] ADDR_RESULT_HI = 8'hA0;
	localparam logic [7:0] ADDR_RESULT_LO = 8'hA1;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'hA2;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'hA3;
	localparam logic [7:0] ADDR_ANALOG_CTRL = 8'hA4;
	localparam logic [7:0] RESET_MODE_ONE = 8'hD2;
	localparam logic [7:0] RESET_MODE_TWO = 8'h76;
	// ============================================================
	// mode one fields
	localparam int ENABLE_BIT = 0;
	localparam int GAIN_LSB = 1;
	localparam int REF_LEVEL_LSB = 4;
	localparam int REF_SOURCE_BIT = 7;
	// mode two fields
	localparam int READY_BIT = 0;
	localparam int OFFSET_LSB = 1;
	localparam int HALVE_BIT = 3;
	localparam int OSR_LSB = 4;
	localparam int SOURCE_BIT = 7;
	// analog control fields (amplifier side)
	localparam int AMP_ENABLE_BIT = 0;
	localparam int INBUF_BIT = 1;
	localparam int REFBUF_BIT = 2;
	localparam int TEMP_SEL_BIT = 3;
	localparam int REG_ENABLE_BIT = 4;
	// ============================================================
	// codes
	localparam logic [2:0] GAIN_UNITY = 3'h1;
	localparam logic [2:0] GAIN_DOUBLE = 3'h2;
	localparam logic [2:0] REF_LEVEL_MAX = 3'h5;
	localparam logic [1:0] OFFSET_HALF = 2'h1;
	localparam logic [1:0] OFFSET_QUARTER = 2'h2;
	localparam logic signed [15:0] RESULT_MAX = 16'sh7FFF;
	localparam logic signed [15:0] RESULT_MIN = 16'sh8000;
	// ============================================================
	// timing: system clock and the two converter clock sources
	localparam int SYS_CLOCK_KHZ = 40000;
	localparam int CONV_FAST_KHZ = 250;
	localparam int CONV_SLOW_KHZ = 166;
	localparam int DIV_FAST = SYS_CLOCK_KHZ / CONV_FAST_KHZ;
	localparam int DIV_SLOW = SYS_CLOCK_KHZ / CONV_SLOW_KHZ;
	localparam int DIV_WIDTH = 10;
	localparam int OSR_WIDTH = 16;
endpackage : sdc_pkg

// ### verilog/sdc_conv_clock.sv
`timescale 1ns/100ps
// ============================================================
// converter clock tick generator: one-cycle pulse at the chosen rate
module sdc_conv_clock #(
	parameter int DIV_FAST = sdc_pkg::DIV_FAST,
	parameter int DIV_SLOW = sdc_pkg::DIV_SLOW
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic run,
	input wire logic source_slow,
	input wire logic halve,
	output logic tick
);
	logic [sdc_pkg::DIV_WIDTH-1:0] count;
	logic [sdc_pkg::DIV_WIDTH-1:0] limit;
	logic half_phase;
	logic base_tick;

	assign limit = source_slow ?
		sdc_pkg::DIV_WIDTH'(DIV_SLOW - 1) :
		sdc_pkg::DIV_WIDTH'(DIV_FAST - 1);
	assign base_tick = run && (count >= limit);
	// halving swallows every other base tick
	assign tick = base_tick && (!halve || half_phase);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count <= '0;
		end else if (!run || base_tick) begin
			count <= '0;
		end else begin
			count <= count + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			half_phase <= 1'b0;
		end else if (!run) begin
			half_phase <= 1'b0;
		end else if (base_tick) begin
			half_phase <= !half_phase;
		end
	end
endmodule : sdc_conv_clock

// ### verilog/sdc_control.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
// Behaviour
// [R1] enable bit stops or runs conversions
// [R2] gain codes 001 unity, 010 double
// [R3] internal reference level codes 000 to 101
// [R4] bit 7 selects internal or external reference
// [R5] ready flag sets on each new word
// [R6] software clears ready after each read
// [R7] offset codes: minus half, minus quarter
// [R8] clock 250/125/166/83 kHz by source, divide
// [R9] one word per oversampling-ratio clocks
// [R10] word rate 3.9 kHz down to 7.6 Hz
// [R11] results signed, clamped to 16-bit range
// [R12] software sets gain 1x for temp sensor
// [R13] temp channel: sensor plus, reference-minus minus
// [R14] gain 1x needs input buffer enabled
// [R15] external reference needs reference buffer
// [R16] keep amplifier on while changing channel
// [R17] regulator enabled before amplifier
// [R18] disabled: no ready, counting restarts
module sdc_control #(
	parameter int DIV_FAST = sdc_pkg::DIV_FAST,
	parameter int DIV_SLOW = sdc_pkg::DIV_SLOW
) (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic signed [23:0] MOD_SUM,
	output logic SAMPLE_TICK,
	output logic CONV_RUN,
	output logic [1:0] GAIN_MULT,
	output logic REF_INTERNAL,
	output logic [2:0] REF_LEVEL,
	output logic [1:0] OFFSET_CODE,
	output logic AMP_ENABLE,
	output logic INPUT_BUFFER_EN,
	output logic REF_BUFFER_EN,
	output logic TEMP_SENSE_SEL,
	output logic AMP_POS_TEMP,
	output logic AMP_NEG_REFMINUS,
	output logic REGULATOR_EN,
	output logic IRQ
);
	// ============================================================
	// registers
	logic [7:0] mode_one;
	logic [7:0] mode_two;
	logic [7:0] analog_ctrl;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	logic signed [15:0] result;
	logic [sdc_pkg::OSR_WIDTH-1:0] osr_count;
	logic [sdc_pkg::OSR_WIDTH-1:0] osr_limit;
	logic conv_tick;
	logic word_done;
	logic enable;
	logic ready_set;
	logic ready_clear;
	logic overrun;
	logic signed [15:0] next_result;
	logic wr_one;
	logic wr_two;

	assign wr_one = WR && (ADDR == sdc_pkg::ADDR_MODE_ONE);
	assign wr_two = WR && (ADDR == sdc_pkg::ADDR_MODE_TWO);
	assign enable = mode_one[sdc_pkg::ENABLE_BIT];

	// ============================================================
	// mode one
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			mode_one <= sdc_pkg::RESET_MODE_ONE;
		end else if (wr_one) begin
			mode_one <= WDATA;
		end
	end

	// ============================================================
	// mode two; the ready flag is hardware-set, software-cleared
	assign ready_set = word_done;
	assign ready_clear = wr_two && !WDATA[sdc_pkg::READY_BIT];
	assign overrun = word_done && mode_two[sdc_pkg::READY_BIT];

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			mode_two <= sdc_pkg::RESET_MODE_TWO;
		end else begin
			if (wr_two) begin
				mode_two[7:1] <= WDATA[7:1];
			end
			// set beats a simultaneous clear so no word is missed
			if (ready_set) begin
				mode_two[sdc_pkg::READY_BIT] <= 1'b1; // R5
			end else if (ready_clear) begin
				mode_two[sdc_pkg::READY_BIT] <= 1'b0; // R6
			end
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			analog_ctrl <= 8'h00;
		end else if (WR && (ADDR == sdc_pkg::ADDR_ANALOG_CTRL)) begin
			analog_ctrl <= WDATA;
		end
	end

	// ============================================================
	// converter clock
	sdc_conv_clock #(
		.DIV_FAST(DIV_FAST),
		.DIV_SLOW(DIV_SLOW)
	) u_clock (
		.clk(CLK),
		.nrst(NRST),
		.run(enable), // R1
		.source_slow(mode_two[sdc_pkg::SOURCE_BIT]), // R8
		.halve(mode_two[sdc_pkg::HALVE_BIT]), // R8
		.tick(conv_tick)
	);

	// ============================================================
	// word rate: oversampling ratio in converter clocks
	always_comb begin
		case (mode_two[sdc_pkg::OSR_LSB +: 3]) // R9 R10
		3'h0: osr_limit = 16'h003F;
		3'h1: osr_limit = 16'h007F;
		3'h2: osr_limit = 16'h00FF;
		3'h3: osr_limit = 16'h03FF;
		3'h4: osr_limit = 16'h0FFF;
		3'h5: osr_limit = 16'h1FFF;
		3'h6: osr_limit = 16'h3FFF;
		default: osr_limit = 16'h7FFF;
		endcase
	end

	assign word_done = enable && conv_tick && (osr_count >= osr_limit);

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			osr_count <= '0;
		end else if (!enable || word_done) begin
			osr_count <= '0; // R18
		end else if (conv_tick) begin
			osr_count <= osr_count + 1'b1; // R9
		end
	end

	// ============================================================
	// result clamp to the signed 16-bit range
	always_comb begin
		if (MOD_SUM > 24'sh007FFF) begin
			next_result = sdc_pkg::RESULT_MAX; // R11
		end else if (MOD_SUM < -24'sh008000) begin
			next_result = sdc_pkg::RESULT_MIN; // R11
		end else begin
			next_result = MOD_SUM[15:0];
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			result <= '0;
		end else if (word_done) begin
			result <= next_result; // R11
		end
	end

	// ============================================================
	// interrupts: bit0 new word, bit1 overrun; write one clears
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			irq_status <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == 0) ? word_done : overrun) begin
					irq_status[i] <= 1'b1;
				end else if (WR && (ADDR == sdc_pkg::ADDR_IRQ_STATUS)
					&& WDATA[i]) begin
					irq_status[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			irq_mask <= 2'h0;
		end else if (WR && (ADDR == sdc_pkg::ADDR_IRQ_MASK)) begin
			irq_mask <= WDATA[1:0];
		end
	end

	assign IRQ = |(irq_status & irq_mask);

	// ============================================================
	// read port: data one cycle after the strobe, zero otherwise
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			RDATA <= 8'h00;
		end else if (RD) begin
			case (ADDR)
			sdc_pkg::ADDR_MODE_ONE: RDATA <= mode_one;
			sdc_pkg::ADDR_MODE_TWO: RDATA <= mode_two;
			sdc_pkg::ADDR_RESULT_HI: RDATA <= result[15:8];
			sdc_pkg::ADDR_RESULT_LO: RDATA <= result[7:0];
			sdc_pkg::ADDR_IRQ_STATUS: RDATA <= {6'h00, irq_status};
			sdc_pkg::ADDR_IRQ_MASK: RDATA <= {6'h00, irq_mask};
			sdc_pkg::ADDR_ANALOG_CTRL: RDATA <= analog_ctrl;
			default: RDATA <= 8'h00;
			endcase
		end else begin
			RDATA <= 8'h00;
		end
	end

	// ============================================================
	// analog front end steering
	assign SAMPLE_TICK = conv_tick;
	assign CONV_RUN = enable; // R1
	// reserved gain codes fall back to unity
	assign GAIN_MULT =
		(mode_one[sdc_pkg::GAIN_LSB +: 3] == sdc_pkg::GAIN_DOUBLE) ?
		2'h2 : 2'h1; // R2
	assign REF_INTERNAL = mode_one[sdc_pkg::REF_SOURCE_BIT]; // R4
	// reserved level codes clip to the top level
	assign REF_LEVEL =
		(mode_one[sdc_pkg::REF_LEVEL_LSB +: 3] > sdc_pkg::REF_LEVEL_MAX) ?
		sdc_pkg::REF_LEVEL_MAX : mode_one[sdc_pkg::REF_LEVEL_LSB +: 3]; // R3
	assign OFFSET_CODE = mode_two[sdc_pkg::OFFSET_LSB +: 2]; // R7
	// software ordering of amplifier, buffers and regulator is its own
	assign AMP_ENABLE = analog_ctrl[sdc_pkg::AMP_ENABLE_BIT];
	assign INPUT_BUFFER_EN = analog_ctrl[sdc_pkg::INBUF_BIT];
	assign REF_BUFFER_EN = analog_ctrl[sdc_pkg::REFBUF_BIT];
	assign TEMP_SENSE_SEL = analog_ctrl[sdc_pkg::TEMP_SEL_BIT];
	assign REGULATOR_EN = analog_ctrl[sdc_pkg::REG_ENABLE_BIT];
	assign AMP_POS_TEMP = TEMP_SENSE_SEL; // R13
	assign AMP_NEG_REFMINUS = TEMP_SENSE_SEL; // R13

	// ============================================================
	// checks
	// clocks since the last tick; the bench shrinks the dividers, so
	// tick spacing is checked against the parameter, not a fixed number
	logic [15:0] tick_gap;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			tick_gap <= '0;
		end else if (!enable || conv_tick) begin
			tick_gap <= '0;
		end else if (tick_gap != '1) begin
			tick_gap <= tick_gap + 1'b1;
		end
	end

	a_ready_sets: assert property (@(posedge CLK) disable iff (!NRST)
		word_done |=> mode_two[sdc_pkg::READY_BIT]) // R5
		else $error("ready flag not set after new word");
	a_ready_holds: assert property (@(posedge CLK) disable iff (!NRST)
		mode_two[sdc_pkg::READY_BIT] && !ready_clear
		|=> mode_two[sdc_pkg::READY_BIT]) // R6
		else $error("ready flag dropped without software clear");
	a_disabled_quiet: assert property (@(posedge CLK) disable iff (!NRST)
		!enable |-> !word_done && !conv_tick) // R1
		else $error("conversion activity while disabled");
	a_restart_count: assert property (@(posedge CLK) disable iff (!NRST)
		!enable |=> osr_count == '0) // R18
		else $error("word counter not reset while disabled");
	a_word_spacing: assert property (@(posedge CLK) disable iff (!NRST)
		word_done |=> !word_done [*8]) // R9
		else $error("words closer than oversampling allows");
	a_result_clamp: assert property (@(posedge CLK) disable iff (!NRST)
		word_done && (MOD_SUM > 24'sh007FFF)
		|=> result == sdc_pkg::RESULT_MAX) // R11
		else $error("positive overflow not clamped");
	a_gain_double: assert property (@(posedge CLK) disable iff (!NRST)
		mode_one[sdc_pkg::GAIN_LSB +: 3] == sdc_pkg::GAIN_DOUBLE
		|-> GAIN_MULT == 2'h2) // R2
		else $error("double gain code not applied");
	a_ref_level: assert property (@(posedge CLK) disable iff (!NRST)
		REF_LEVEL <= sdc_pkg::REF_LEVEL_MAX) // R3
		else $error("reference level outside legal codes");
	a_temp_route: assert property (@(posedge CLK) disable iff (!NRST)
		TEMP_SENSE_SEL |-> AMP_POS_TEMP && AMP_NEG_REFMINUS) // R13
		else $error("temperature routing wrong");
	a_tick_rate: assert property (@(posedge CLK) disable iff (!NRST) // R8
		conv_tick |-> int'(tick_gap) >= (DIV_FAST - 1))
		else $error("converter clock faster than allowed");
	a_ready_clears: assert property (@(posedge CLK) disable iff (!NRST) // R6
		ready_clear && !ready_set |=> !mode_two[sdc_pkg::READY_BIT])
		else $error("ready flag not cleared by software");
	a_ready_quiet: assert property (@(posedge CLK) disable iff (!NRST) // R18
		!enable && !mode_two[sdc_pkg::READY_BIT]
		|=> !mode_two[sdc_pkg::READY_BIT])
		else $error("ready flag set while disabled");
	a_word_on_tick: assert property (@(posedge CLK) disable iff (!NRST) // R9
		word_done |-> conv_tick && (osr_count == osr_limit))
		else $error("word ended off its last converter tick");
	a_osr_bound: assert property (@(posedge CLK) disable iff (!NRST) // R9
		enable |-> osr_count <= osr_limit)
		else $error("word counter beyond oversampling ratio");
	a_clamp_low: assert property (@(posedge CLK) disable iff (!NRST) // R11
		word_done && (MOD_SUM < -24'sh008000)
		|=> result == sdc_pkg::RESULT_MIN)
		else $error("negative overflow not clamped");
	a_result_pass: assert property (@(posedge CLK) disable iff (!NRST) // R11
		word_done && (MOD_SUM <= 24'sh007FFF) && (MOD_SUM >= -24'sh008000)
		|=> result == $past(MOD_SUM[15:0]))
		else $error("in-range result altered");
	a_result_hold: assert property (@(posedge CLK) disable iff (!NRST) // R5
		!word_done |=> $stable(result))
		else $error("result changed without a new word");
	a_word_irq: assert property (@(posedge CLK) disable iff (!NRST) // R5
		word_done |=> irq_status[0])
		else $error("new word status not set");
	a_overrun_irq: assert property (@(posedge CLK) disable iff (!NRST) // R6
		overrun |=> irq_status[1])
		else $error("overrun status not set");
	a_status_clear: assert property (@(posedge CLK) disable iff (!NRST)
		WR && (ADDR == sdc_pkg::ADDR_IRQ_STATUS) && WDATA[0] && !word_done
		|=> !irq_status[0])
		else $error("status bit not cleared by write of one");
	a_rdata_idle: assert property (@(posedge CLK) disable iff (!NRST)
		!RD |=> RDATA == 8'h00)
		else $error("read data outside its cycle");
	a_rdata_mode: assert property (@(posedge CLK) disable iff (!NRST) // R5
		RD && (ADDR == sdc_pkg::ADDR_MODE_TWO) |=> RDATA == $past(mode_two))
		else $error("mode two read back wrong");
	a_analog_write: assert property (@(posedge CLK) disable iff (!NRST) // R17
		WR && (ADDR == sdc_pkg::ADDR_ANALOG_CTRL)
		|=> analog_ctrl == $past(WDATA))
		else $error("analog control write lost");
	a_gain_unity: assert property (@(posedge CLK) disable iff (!NRST) // R2
		mode_one[sdc_pkg::GAIN_LSB +: 3] != sdc_pkg::GAIN_DOUBLE
		|-> GAIN_MULT == 2'h1)
		else $error("unity gain not applied");
	a_ref_pass: assert property (@(posedge CLK) disable iff (!NRST) // R3
		mode_one[sdc_pkg::REF_LEVEL_LSB +: 3] <= sdc_pkg::REF_LEVEL_MAX
		|-> REF_LEVEL == mode_one[sdc_pkg::REF_LEVEL_LSB +: 3])
		else $error("legal reference level not passed on");
	c_word: cover property (@(posedge CLK) disable iff (!NRST) word_done);
	c_overrun: cover property (@(posedge CLK) disable iff (!NRST) overrun);
	c_set_clear: cover property (@(posedge CLK) disable iff (!NRST)
		ready_set && ready_clear);
	c_irq: cover property (@(posedge CLK) disable iff (!NRST) IRQ);
endmodule : sdc_control

// ### sim/tb_sigma_delta_adc_control.sv
`timescale 1ns/100ps
module tb_sigma_delta_adc_control;
	logic CLK, NRST, WR, RD, rd_seen;
	logic [7:0] ADDR, WDATA, RDATA, v;
	logic signed [23:0] MOD_SUM;
	logic SAMPLE_TICK, CONV_RUN, REF_INTERNAL, AMP_ENABLE, INPUT_BUFFER_EN;
	logic REF_BUFFER_EN, TEMP_SENSE_SEL, AMP_POS_TEMP, AMP_NEG_REFMINUS;
	logic REGULATOR_EN, IRQ;
	logic [1:0] GAIN_MULT, OFFSET_CODE;
	logic [2:0] REF_LEVEL;
	logic [15:0] res;
	logic [7:0] exp_q[$];
	int err_count, checked;
	int ratio[4] = '{64, 128, 256, 1024};
	int per[4] = '{2, 4, 3, 6};
	logic [7:0] clk_cfg[4] = '{8'h00, 8'h08, 8'h80, 8'h88};
	// regulator first, amplifier kept on while the channel changes
	logic [7:0] ana[4] = '{8'h10, 8'h13, 8'h17, 8'h1B};

	// dividers shortened so a 64-tick word takes 128 clocks
	sdc_control #(.DIV_FAST(2), .DIV_SLOW(3)) i_dut (.CLK(CLK), .NRST(NRST),
		.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.MOD_SUM(MOD_SUM), .SAMPLE_TICK(SAMPLE_TICK), .CONV_RUN(CONV_RUN),
		.GAIN_MULT(GAIN_MULT), .REF_INTERNAL(REF_INTERNAL),
		.REF_LEVEL(REF_LEVEL), .OFFSET_CODE(OFFSET_CODE),
		.AMP_ENABLE(AMP_ENABLE), .INPUT_BUFFER_EN(INPUT_BUFFER_EN),
		.REF_BUFFER_EN(REF_BUFFER_EN), .TEMP_SENSE_SEL(TEMP_SENSE_SEL),
		.AMP_POS_TEMP(AMP_POS_TEMP), .AMP_NEG_REFMINUS(AMP_NEG_REFMINUS),
		.REGULATOR_EN(REGULATOR_EN), .IRQ(IRQ));

	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end

	// ============================================================
	// checking
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic close_out();
		$display("Compares %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out

	// read data belong to the cycle after the strobe only
	always @(posedge CLK) begin
		if (rd_seen === 1'b1) begin
			if (exp_q.size() == 0)
				chk("read queue", 16'h0001, 16'h0000);
			else
				chk("RDATA", 16'(RDATA), 16'(exp_q.pop_front()));
		end
		rd_seen <= RD;
	end

	// ============================================================
	// register bus
	task automatic wr(input logic [7:0] a, d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, e);
		@(posedge CLK);
		exp_q.push_back(e);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
	endtask : rd

	// n_exp 0: only wait for the interrupt, count unknown
	task automatic wait_word(input int n_exp);
		int t;
		int c;
		t = 0;
		for (c = 0; c < 40000; c++) begin
			if (n_exp > 0 ? t == n_exp : IRQ === 1'b1)
				break;
			// mid-cycle sampling keeps the last tick apart from its edge
			@(negedge CLK);
			if (SAMPLE_TICK === 1'b1)
				t++;
		end
		if (c == 40000) begin
			$display("Error word wait expected done seen timeout");
			err_count++;
			close_out();
		end
		if (n_exp > 0) begin
			chk("irq early", 16'(IRQ), 16'h0000);
			repeat (2) @(posedge CLK);
			chk("irq late", 16'(IRQ), 16'h0001);
		end
	endtask : wait_word

	task automatic period(input int exp);
		int c;
		int first;
		int cnt;
		cnt = 0;
		first = 0;
		for (c = 0; c < 64 && cnt < 2; c++) begin
			@(posedge CLK);
			if (SAMPLE_TICK === 1'b1) begin
				if (cnt == 0)
					first = c;
				cnt++;
			end
		end
		chk("tick period", 16'(c - 1 - first), 16'(exp));
	endtask : period

	// ============================================================
	// main sequence
	initial begin
		void'($urandom(61));
		NRST = 1'b0;
		ADDR = 8'h00;
		WDATA = 8'h00;
		WR = 1'b0;
		RD = 1'b0;
		rd_seen = 1'b0;
		MOD_SUM = 24'h000000;
		err_count = 0;
		checked = 0;
		repeat (12) @(posedge CLK);
		NRST <= 1'b1;
		@(negedge CLK);
		chk("run", 16'(CONV_RUN), 16'h0000);
		chk("offset", 16'(OFFSET_CODE), 16'h0003);
		rd(sdc_pkg::ADDR_MODE_ONE, sdc_pkg::RESET_MODE_ONE);
		rd(sdc_pkg::ADDR_MODE_TWO, sdc_pkg::RESET_MODE_TWO);
		wr(8'h00, 8'hFF);
		rd(8'h00, 8'h00);
		for (int i = 0; i < 8; i++) begin
			v = {1'($urandom), i[2:0], i[2:0], 1'b0};
			wr(sdc_pkg::ADDR_MODE_ONE, v);
			@(negedge CLK);
			chk("gain", 16'(GAIN_MULT), (i == 2) ? 16'h0002 : 16'h0001);
			chk("ref level", 16'(REF_LEVEL), 16'((i > 5) ? 5 : i));
			chk("ref source", 16'(REF_INTERNAL), 16'(v[7]));
			rd(sdc_pkg::ADDR_MODE_ONE, v);
		end
		for (int i = 0; i < 4; i++) begin
			v = {5'h00, i[1:0], 1'b0};
			wr(sdc_pkg::ADDR_MODE_TWO, v);
			@(negedge CLK);
			chk("offset", 16'(OFFSET_CODE), 16'(i));
		end
		// gain left at unity for the bypass and temperature cases
		wr(sdc_pkg::ADDR_MODE_ONE, 8'hD2);
		for (int i = 0; i < 4; i++) begin
			wr(sdc_pkg::ADDR_ANALOG_CTRL, ana[i]);
			@(negedge CLK);
			chk("analog", 16'({REGULATOR_EN, TEMP_SENSE_SEL, REF_BUFFER_EN,
				INPUT_BUFFER_EN, AMP_ENABLE}), 16'(ana[i][4:0]));
			chk("temp route", 16'({AMP_POS_TEMP, AMP_NEG_REFMINUS}),
				16'({2{ana[i][3]}}));
		end
		for (int k = 0; k < 4; k++) begin
			wr(sdc_pkg::ADDR_MODE_ONE, 8'hD2);
			wr(sdc_pkg::ADDR_MODE_TWO, clk_cfg[k]);
			wr(sdc_pkg::ADDR_MODE_ONE, 8'hD3);
			period(per[k]);
		end
		wr(sdc_pkg::ADDR_IRQ_MASK, 8'h01);
		for (int k = 0; k < 4; k++) begin
			wr(sdc_pkg::ADDR_MODE_ONE, 8'hD2);
			wr(sdc_pkg::ADDR_IRQ_STATUS, 8'h03);
			wr(sdc_pkg::ADDR_MODE_TWO, {1'b0, k[2:0], 4'h0});
			wr(sdc_pkg::ADDR_MODE_ONE, 8'hD3);
			wait_word(ratio[k]);
		end
		// ========================================================
		// abort mid-word, then a full word from scratch
		wr(sdc_pkg::ADDR_MODE_ONE, 8'hD2);
		wr(sdc_pkg::ADDR_IRQ_STATUS, 8'h03);
		wr(sdc_pkg::ADDR_MODE_TWO, 8'h00);
		res = 16'($urandom);
		MOD_SUM <= 24'(signed'(res));
		wr(sdc_pkg::ADDR_MODE_ONE, 8'hD3);
		repeat (80) @(posedge CLK);
		wr(sdc_pkg::ADDR_MODE_ONE, 8'hD2);
		for (int c = 0; c < 300; c++) begin
			@(posedge CLK);
			chk("idle", 16'({SAMPLE_TICK, IRQ}), 16'h0000);
		end
		wr(sdc_pkg::ADDR_MODE_ONE, 8'hD3);
		wait_word(64);
		MOD_SUM <= 24'sh123456;
		rd(sdc_pkg::ADDR_MODE_TWO, 8'h01);
		rd(sdc_pkg::ADDR_RESULT_HI, res[15:8]);
		rd(sdc_pkg::ADDR_RESULT_LO, res[7:0]);
		wr(sdc_pkg::ADDR_IRQ_STATUS, 8'h01);
		@(negedge CLK);
		chk("irq clear", 16'(IRQ), 16'h0000);
		wait_word(0);
		// flag never cleared by software, so it stands and overruns
		rd(sdc_pkg::ADDR_IRQ_STATUS, 8'h03);
		rd(sdc_pkg::ADDR_MODE_TWO, 8'h01);
		rd(sdc_pkg::ADDR_RESULT_HI, 8'h7F);
		rd(sdc_pkg::ADDR_RESULT_LO, 8'hFF);
		wr(sdc_pkg::ADDR_IRQ_MASK, 8'h00);
		@(negedge CLK);
		chk("irq masked", 16'(IRQ), 16'h0000);
		wr(sdc_pkg::ADDR_IRQ_MASK, 8'h03);
		@(negedge CLK);
		chk("irq unmasked", 16'(IRQ), 16'h0001);
		MOD_SUM <= -24'sh100000;
		wr(sdc_pkg::ADDR_IRQ_STATUS, 8'h03);
		wr(sdc_pkg::ADDR_MODE_TWO, 8'h00);
		rd(sdc_pkg::ADDR_MODE_TWO, 8'h00);
		wait_word(0);
		rd(sdc_pkg::ADDR_RESULT_HI, 8'h80);
		rd(sdc_pkg::ADDR_RESULT_LO, 8'h00);
		repeat (3) @(posedge CLK);
		close_out();
	end
endmodule : tb_sigma_delta_adc_control
